//--- hw/axil_reg_slave.sv
// AXI4-Lite slave front end: turns bus traffic into register strobes.
// Assumes a register bank answering reads and write errors combinationally.
`timescale 1ns/1ns
`include "link_cap_regs.svh"

module axil_reg_slave
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [`ADDR_W-1:0]      awaddr,
  input  wire logic                    wvalid,
  output logic                         wready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  output logic                         bvalid,
  input  wire logic                    bready,
  output logic [1:0]                   bresp,
  input  wire logic                    arvalid,
  output logic                         arready,
  input  wire logic [`ADDR_W-1:0]      araddr,
  output logic                         rvalid,
  input  wire logic                    rready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         wr_en,
  output link_cap_pkg::reg_wr_t        wr,
  input  wire logic                    wr_err,
  output logic [`ADDR_W-1:0]           rd_addr,
  input  wire link_cap_pkg::reg_rd_t   rd
);
  import link_cap_pkg::*;

  logic               aw_have_q;
  logic [`ADDR_W-1:0] aw_addr_q;
  logic               w_have_q;
  logic [31:0]        w_data_q;
  logic [3:0]         w_strb_q;
  logic               bvalid_q;
  logic [1:0]         bresp_q;
  logic               rvalid_q;
  logic [31:0]        rdata_q;
  logic [1:0]         rresp_q;

  // ----------------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------------
  // Address and data land in either order; commit once both are held
  assign awready = !aw_have_q && !bvalid_q;
  assign wready  = !w_have_q && !bvalid_q;
  assign wr_en   = aw_have_q && w_have_q && !bvalid_q;
  assign wr      = '{addr: aw_addr_q, data: w_data_q, strb: w_strb_q};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      else if (wr_en)
        aw_have_q <= 1'b0;
      if (wvalid && wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      else if (wr_en)
        w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OKAY;
    end
    else if (wr_en)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (bready)
      bvalid_q <= 1'b0;
  end

  assign bvalid = bvalid_q;
  assign bresp  = bresp_q;

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  assign arready = !rvalid_q;
  assign rd_addr = araddr;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd.data;
      rresp_q  <= rd.err ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (rready)
      rvalid_q <= 1'b0;
  end

  assign rvalid = rvalid_q;
  assign rdata  = rdata_q;
  assign rresp  = rresp_q;

endmodule

//--- hw/link_cap_pkg.sv
// Types shared by the link capability bank and its bus front end.
// Assumes link_cap_regs.svh on the include path.
`include "link_cap_regs.svh"

package link_cap_pkg;

  // --------------------------------------------------------------------
  // Register access carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [31:0]        data;
    logic [3:0]         strb;
  } reg_wr_t;

  typedef struct packed {
    logic [31:0] data;
    logic        err;
  } reg_rd_t;

  // --------------------------------------------------------------------
  // Link capability word, bit 31 first
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [10:0] rsvd_hi;
    logic        dla;
    logic        sdr;
    logic        cpm;
    logic [2:0]  l1;
    logic [2:0]  l0s;
    logic [1:0]  pss;
    logic [5:0]  width;
    logic [3:0]  spd;
  } link_cap_t;

  // Values handed to the link logic
  typedef struct packed {
    logic [5:0] eff_width;
    logic [1:0] pss;
    logic [2:0] l0s;
    logic [2:0] l1;
    logic       cpm;
    logic       sdr;
    logic       dla;
  } link_out_t;

  typedef enum logic [2:0] {
    st_idle  = 3'b001,
    st_req   = 3'b010,
    st_train = 3'b100
  } retrain_state_t;

endpackage

//--- hw/link_cap_regs.svh
// Offsets, field positions, reset values and codes of the link capability bank.
// Assumes inclusion by bare name; definitions only.
`ifndef LINK_CAP_REGS_SVH
`define LINK_CAP_REGS_SVH

// ----------------------------------------------------------------------
// Addressing
// ----------------------------------------------------------------------
`define ADDR_W          12
`define OFS_LINK_CAP    12'h04C
`define OFS_CERR_STAT   12'h100
`define OFS_LINK_STATE  12'h104

// ----------------------------------------------------------------------
// Field positions in the link capability word
// ----------------------------------------------------------------------
`define SPD_LSB  0
`define WID_LSB  4
`define PSS_LSB  10
`define L0S_LSB  12
`define L1_LSB   15
`define CPM_BIT  18
`define SDR_BIT  19
`define DLA_BIT  20

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define SPD_RST     4'h2
`define PSS_RST     2'h3
`define L0S_RST     3'h6
`define L1_RST      3'h2
`define CPM_RST     1'h0
`define SDR_DN_RST  1'h1
`define DLA_DN_RST  1'h1
`define WID_X1      6'h01
`define WID_X2      6'h02
`define WID_X4      6'h04
`define WID_X12     6'h0C
`define WID_X16     6'h0D
`define WID_X32     6'h20
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

//--- hw/link_capability_register.sv
// Link capability register of one switch port, with width override and retrain.
// Assumes link training logic on aclk that answers retrain_req with
// retrain_ack and reports retrain_done when the link is back in L0.
`timescale 1ns/1ns
`include "link_cap_regs.svh"

module link_capability_register
#(
  parameter logic       IS_DOWNSTREAM   = 1'b1,
  parameter logic [5:0] INIT_WIDTH_CODE = `WID_X4
)
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [`ADDR_W-1:0]      awaddr,
  input  wire logic                    wvalid,
  output logic                         wready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  output logic                         bvalid,
  input  wire logic                    bready,
  output logic [1:0]                   bresp,
  input  wire logic                    arvalid,
  output logic                         arready,
  input  wire logic [`ADDR_W-1:0]      araddr,
  output logic                         rvalid,
  input  wire logic                    rready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  input  wire logic                    port_disabled,
  output logic                         retrain_req,
  input  wire logic                    retrain_ack,
  input  wire logic                    retrain_done,
  input  wire logic                    rx_error,
  output link_cap_pkg::link_out_t      link_out
);
  import link_cap_pkg::*;

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic width_valid(input logic [5:0] code);
    case (code)
      `WID_X1, `WID_X2, `WID_X4, `WID_X12, `WID_X16, `WID_X32: width_valid = 1'b1;
      default: width_valid = 1'b0;
    endcase
  endfunction

  function automatic logic addr_hit(input logic [`ADDR_W-1:0] addr);
    case (addr)
      `OFS_LINK_CAP, `OFS_CERR_STAT, `OFS_LINK_STATE: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[8*i +: 8] = new_w[8*i +: 8];
    end
    merge = r;
  endfunction

  // ----------------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------------
  logic               wr_en;
  reg_wr_t            wr;
  logic               wr_err;
  logic [`ADDR_W-1:0] rd_addr;
  reg_rd_t            rd;

  axil_reg_slave axil_reg_slave_i
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .araddr  (araddr),
    .rvalid  (rvalid),
    .rready  (rready),
    .rdata   (rdata),
    .rresp   (rresp),
    .wr_en   (wr_en),
    .wr      (wr),
    .wr_err  (wr_err),
    .rd_addr (rd_addr),
    .rd      (rd)
  );

  assign wr_err = !addr_hit(wr.addr);

  // ----------------------------------------------------------------------
  // Link capability word
  // ----------------------------------------------------------------------
  link_cap_t      cap_q;
  link_cap_t      cap_new;
  logic           cap_wr;
  logic           width_changed;

  assign cap_wr        = wr_en && (wr.addr == `OFS_LINK_CAP);
  assign cap_new       = link_cap_t'(merge(32'(cap_q), wr.data, wr.strb));
  assign width_changed = cap_wr && (cap_new.width != cap_q.width);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cap_q.rsvd_hi <= 11'h000;
      cap_q.spd     <= `SPD_RST;
      cap_q.width   <= INIT_WIDTH_CODE;
      cap_q.pss     <= `PSS_RST;
      cap_q.l0s     <= `L0S_RST;
      cap_q.l1      <= `L1_RST;
      cap_q.cpm     <= `CPM_RST;
      cap_q.sdr     <= IS_DOWNSTREAM ? `SDR_DN_RST : 1'b0;
      cap_q.dla     <= IS_DOWNSTREAM ? `DLA_DN_RST : 1'b0;
    end
    else if (cap_wr)
    begin
      cap_q.width <= cap_new.width;
      cap_q.pss   <= cap_new.pss;
      cap_q.l0s   <= cap_new.l0s;
      cap_q.l1    <= cap_new.l1;
      cap_q.cpm   <= cap_new.cpm;
      cap_q.sdr   <= IS_DOWNSTREAM ? cap_new.sdr : 1'b0;
      cap_q.dla   <= IS_DOWNSTREAM ? cap_new.dla : 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Values driven to the link logic
  // ----------------------------------------------------------------------
  logic [5:0] eff_width;

  assign eff_width = width_valid(cap_q.width) ? cap_q.width : INIT_WIDTH_CODE;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      link_out <= '{eff_width: INIT_WIDTH_CODE, pss: `PSS_RST, l0s: `L0S_RST,
                    l1: `L1_RST, cpm: `CPM_RST,
                    sdr: IS_DOWNSTREAM ? `SDR_DN_RST : 1'b0,
                    dla: IS_DOWNSTREAM ? `DLA_DN_RST : 1'b0};
    end
    else
    begin
      link_out <= '{eff_width: eff_width, pss: cap_q.pss, l0s: cap_q.l0s,
                    l1: cap_q.l1, cpm: cap_q.cpm, sdr: cap_q.sdr,
                    dla: cap_q.dla};
    end
  end

  // ----------------------------------------------------------------------
  // Retrain sequencing
  // ----------------------------------------------------------------------
  retrain_state_t st_q;
  retrain_state_t st_d;
  logic           start;
  logic           pend_q;
  logic [7:0]     retrain_cnt_q;

  assign start = width_changed && !port_disabled;

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      st_idle:
      begin
        if (start)
          st_d = st_req;
      end
      st_req:
      begin
        if (retrain_ack)
          st_d = st_train;
      end
      st_train:
      begin
        // Width changed mid-training: run once more with the new value
        if (retrain_done)
          st_d = (pend_q || start) ? st_req : st_idle;
      end
      default: st_d = st_idle;
    endcase
    if (port_disabled)
      st_d = st_idle;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_q <= st_idle;
    else
      st_q <= st_d;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pend_q <= 1'b0;
    else if (port_disabled || (st_q == st_train && retrain_done))
      pend_q <= 1'b0;
    else if (start && st_q == st_train)
      pend_q <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      retrain_cnt_q <= 8'h00;
    else if (st_d == st_req && st_q != st_req)
      retrain_cnt_q <= retrain_cnt_q + 8'h01;
  end

  assign retrain_req = (st_q == st_req);

  // ----------------------------------------------------------------------
  // Correctable receiver error log
  // ----------------------------------------------------------------------
  logic [1:0] cerr_q;
  logic [1:0] cerr_set;
  logic [1:0] cerr_clr;

  assign cerr_set = {rx_error && (st_q != st_idle), rx_error};
  assign cerr_clr = (wr_en && wr.addr == `OFS_CERR_STAT && wr.strb[0]) ? wr.data[1:0] : 2'h0;

  // Set wins over a same-cycle write-one-to-clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cerr_q <= 2'h0;
    else
      cerr_q <= (cerr_q & ~cerr_clr) | cerr_set;
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  always_comb
  begin
    rd = '{data: 32'h0000_0000, err: 1'b0};
    case (rd_addr)
      `OFS_LINK_CAP:   rd.data = 32'(cap_q);
      `OFS_CERR_STAT:  rd.data = {30'h0000_0000, cerr_q};
      `OFS_LINK_STATE: rd.data = {8'h00, retrain_cnt_q, 5'h00, st_q,
                                  pend_q, !width_valid(cap_q.width), eff_width};
      default:         rd.err  = 1'b1;
    endcase
  end

endmodule

//--- verif/link_capability_register_chk.sv
// Assertions on the link capability bank, bound to its top module.
// Assumes link_cap_pkg compiled first and the register header on the include path.
`timescale 1ns/1ns
`include "link_cap_regs.svh"

module link_capability_register_chk
#(
  parameter logic       IS_DOWNSTREAM   = 1'b1,
  parameter logic [5:0] INIT_WIDTH_CODE = `WID_X4
)
(
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    arvalid,
  input wire logic                    arready,
  input wire logic [`ADDR_W-1:0]      araddr,
  input wire logic                    rvalid,
  input wire logic                    rready,
  input wire logic [31:0]             rdata,
  input wire logic [1:0]              rresp,
  input wire logic                    bvalid,
  input wire logic                    bready,
  input wire logic [1:0]              bresp,
  input wire logic                    port_disabled,
  input wire logic                    retrain_req,
  input wire logic                    retrain_ack,
  input wire link_cap_pkg::link_out_t link_out
);
  import link_cap_pkg::*;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [`ADDR_W-1:0] rd_addr_q;
  logic               cap_rd;

  always_ff @(posedge aclk)
    if (!aresetn)
      rd_addr_q <= '0;
    else if (arvalid && arready)
      rd_addr_q <= araddr;

  assign cap_rd = rvalid && (rd_addr_q == `OFS_LINK_CAP);

  function automatic logic width_ok(input logic [5:0] c);
    return c inside {`WID_X1, `WID_X2, `WID_X4, `WID_X12, `WID_X16, `WID_X32};
  endfunction

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_speed_fixed: assert property (cap_rd |-> rdata[3:0] == `SPD_RST && rresp == `RESP_OKAY)
    else $error("speed field not fixed at its reset code");
  a_width_follows: assert property (cap_rd |->
    link_out.eff_width == (width_ok(rdata[9:4]) ? rdata[9:4] : INIT_WIDTH_CODE))
    else $error("effective width does not follow the width field");
  a_high_bits_zero: assert property (cap_rd |->
    rdata[31:21] == 11'h000 && (IS_DOWNSTREAM || rdata[20:19] == 2'h0))
    else $error("upper capability bits not zero");
  a_reset_fields: assert property ($rose(aresetn) |->
    link_out.pss == `PSS_RST && link_out.l0s == `L0S_RST && link_out.l1 == `L1_RST
    && link_out.cpm == `CPM_RST && link_out.sdr == IS_DOWNSTREAM && link_out.dla == IS_DOWNSTREAM)
    else $error("link outputs not at reset values");
  a_no_retrain_off: assert property (port_disabled |=> !retrain_req)
    else $error("retrain request while port disabled");
  a_req_holds: assert property (retrain_req && !retrain_ack && !port_disabled |=> retrain_req)
    else $error("retrain request dropped before acknowledge");
  a_req_after_ack: assert property (retrain_req && retrain_ack && !port_disabled |=> !retrain_req)
    else $error("retrain request stays after acknowledge");
  a_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response not held");
  a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");

  c_retrain: cover property ($rose(retrain_req));
  c_ack: cover property (retrain_req && retrain_ack);
  c_write: cover property (bvalid && bready);
  c_cap_read: cover property (cap_rd && rready);
endmodule

bind link_capability_register link_capability_register_chk #(.IS_DOWNSTREAM(IS_DOWNSTREAM),
  .INIT_WIDTH_CODE(INIT_WIDTH_CODE)) link_capability_register_chk_i (.aclk(aclk), .aresetn(aresetn),
  .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
  .rdata(rdata), .rresp(rresp), .bvalid(bvalid), .bready(bready), .bresp(bresp),
  .port_disabled(port_disabled), .retrain_req(retrain_req), .retrain_ack(retrain_ack),
  .link_out(link_out));

//--- verif/link_capability_register_tb.sv
// Self-checking bench for the link capability bank over AXI4-Lite.
// Assumes the bench also plays the link training logic.
`timescale 1ns/1ns
`include "link_cap_regs.svh"

module link_capability_register_tb;
  import link_cap_pkg::*;

  logic               aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic               awready, wready, bvalid, arready, rvalid, retrain_req;
  logic               port_disabled, retrain_ack, retrain_done, rx_error;
  logic [`ADDR_W-1:0] awaddr, araddr;
  logic [31:0]        wdata, rdata, exp;
  logic [3:0]         wstrb;
  logic [1:0]         bresp, rresp;
  link_out_t          link_out;
  int                 errors, compares;
  logic [5:0]         codes [0:7] = '{`WID_X16, `WID_X12, `WID_X4, `WID_X2, `WID_X1, 6'h00, 6'h03, 6'h3F};

  link_capability_register #(.IS_DOWNSTREAM(1'b1), .INIT_WIDTH_CODE(`WID_X32)) link_capability_register_i (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .port_disabled(port_disabled),
    .retrain_req(retrain_req), .retrain_ack(retrain_ack), .retrain_done(retrain_done),
    .rx_error(rx_error), .link_out(link_out));

  initial aclk = 1'b0;
  always #25 aclk = ~aclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] cap_word(input logic [5:0] w, input logic [1:0] p,
    input logic [2:0] l0, input logic [2:0] l1, input logic c, input logic s, input logic d);
    return {11'h000, d, s, c, l1, l0, p, w, `SPD_RST};
  endfunction

  // Link outputs expected from a capability word and an effective width
  function automatic logic [31:0] out_word(input logic [31:0] cw, input logic [5:0] eff);
    return {15'h0000, eff, cw[11:10], cw[14:12], cw[17:15], cw[18], cw[19], cw[20]};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, want, seen);
    end
  endtask

  task automatic stop_test;
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr_chk(input logic [`ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      aw_ok = aw_ok | (awvalid & awready);
      w_ok = w_ok | (wvalid & wready);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    // Ready raised late so the slave must hold its answer
    bready <= 1'b1;
    @(posedge aclk);
    check("bresp", {30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd_chk(input logic [`ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b1;
    @(posedge aclk);
    check("rresp", {30'h0, rresp}, {30'h0, er});
    check("rdata", rdata, d);
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Plays the training logic; a receiver error lands while training
  task automatic retrain;
    check("req raised", {31'h0, retrain_req}, 32'h1);
    retrain_ack <= 1'b1;
    @(posedge aclk);
    retrain_ack <= 1'b0;
    rx_error <= 1'b1;
    @(posedge aclk);
    rx_error <= 1'b0;
    check("req after ack", {31'h0, retrain_req}, 32'h0);
    retrain_done <= 1'b1;
    @(posedge aclk);
    retrain_done <= 1'b0;
    @(posedge aclk);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    #200000;
    errors++;
    stop_test();
  end

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {port_disabled, retrain_ack, retrain_done, rx_error} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    aresetn = 1'b0;
    errors = 0;
    compares = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    exp = cap_word(`WID_X32, `PSS_RST, `L0S_RST, `L1_RST, `CPM_RST, `SDR_DN_RST, `DLA_DN_RST);
    rd_chk(`OFS_LINK_CAP, exp, `RESP_OKAY);
    check("reset outputs", {15'h0000, link_out}, out_word(exp, `WID_X32));
    rd_chk(`OFS_LINK_STATE, {16'h0000, 5'h00, 3'h1, 2'h0, `WID_X32}, `RESP_OKAY);
    // Speed bits ignore writes; unchanged width must not retrain
    wr_chk(`OFS_LINK_CAP, exp | 32'h0000000F, `RESP_OKAY);
    check("no retrain", {31'h0, retrain_req}, 32'h0);
    rd_chk(`OFS_LINK_CAP, exp, `RESP_OKAY);
    rx_error <= 1'b1;
    @(posedge aclk);
    rx_error <= 1'b0;
    @(posedge aclk);
    rd_chk(`OFS_CERR_STAT, 32'h00000001, `RESP_OKAY);
    wr_chk(`OFS_CERR_STAT, 32'h00000003, `RESP_OKAY);
    // Width codes only below the default, then reserved ones falling back to it
    for (int i = 0; i < 8; i++)
    begin
      exp = cap_word(codes[i], `PSS_RST, `L0S_RST, `L1_RST, `CPM_RST, `SDR_DN_RST, `DLA_DN_RST);
      wr_chk(`OFS_LINK_CAP, exp, `RESP_OKAY);
      retrain();
      rd_chk(`OFS_LINK_CAP, exp, `RESP_OKAY);
      check("eff width", {15'h0000, link_out}, out_word(exp, (i < 5) ? codes[i] : `WID_X32));
    end
    rd_chk(`OFS_LINK_STATE, {8'h00, 8'h08, 5'h00, 3'h1, 2'h1, `WID_X32}, `RESP_OKAY);
    rd_chk(`OFS_CERR_STAT, 32'h00000003, `RESP_OKAY);
    wr_chk(`OFS_CERR_STAT, 32'h00000003, `RESP_OKAY);
    rd_chk(`OFS_CERR_STAT, 32'h00000000, `RESP_OKAY);
    // Width change while disabled: no retrain, now or later
    port_disabled <= 1'b1;
    exp = cap_word(`WID_X1, 2'h1, 3'h3, 3'h5, 1'h1, 1'h0, 1'h0);
    wr_chk(`OFS_LINK_CAP, exp, `RESP_OKAY);
    check("no retrain off", {31'h0, retrain_req}, 32'h0);
    port_disabled <= 1'b0;
    rd_chk(`OFS_LINK_CAP, exp, `RESP_OKAY);
    check("override outs", {15'h0000, link_out}, out_word(exp, `WID_X1));
    check("still idle", {31'h0, retrain_req}, 32'h0);
    wr_chk(12'h200, 32'hFFFFFFFF, `RESP_SLVERR);
    rd_chk(12'h200, 32'h00000000, `RESP_SLVERR);
    // Reset in mid-run restores every field
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    exp = cap_word(`WID_X32, `PSS_RST, `L0S_RST, `L1_RST, `CPM_RST, `SDR_DN_RST, `DLA_DN_RST);
    rd_chk(`OFS_LINK_CAP, exp, `RESP_OKAY);
    stop_test();
  end
endmodule
